//--- three_wire_regs.svh
// Constants for the three-wire control slave: field positions, codes and identification values.
`ifndef THREE_WIRE_REGS_SVH
`define THREE_WIRE_REGS_SVH

// ****************************************************************
// Address byte layout
// ****************************************************************
`define OA_MSB          7
`define OA_LSB          2
`define DOM_HI_BIT      1
`define DOM_LO_BIT      0
`define SPECIAL_OA      6'h00

// ****************************************************************
// Operation mode codes on the special address, {hi, lo}
// ****************************************************************
`define DOM_RESET       2'h0
`define DOM_DECLARE     2'h1
`define DOM_INVALIDATE  2'h2
`define DOM_RESERVED    2'h3

// ****************************************************************
// Bit framing
// ****************************************************************
`define ID_CONT_BIT     0
`define BIT_FIRST       3'h0
`define BIT_LAST        3'h7
`define IDX_FIRST       2'h0
`define IDX_SECOND      2'h1

// ****************************************************************
// Identification codes, three bytes each, byte 0 in the low bits.
// The values are arbitrary.
// ****************************************************************
`define ID_CODE_0       24'h4a35c3
`define ID_CODE_1       24'h4c35c3
`define ID_CODE_2       24'h4e35c3
`define ID_CODE_3       24'h5035c3

`endif

//--- three_wire_pkg.sv
// Types shared by the three-wire control slave files.
package three_wire_pkg;

   typedef enum logic [2:0] {
      XFER_IDLE,
      XFER_ACTIVE,
      XFER_DECL_ID,
      XFER_DECL_ADDR,
      XFER_INVAL_ID,
      XFER_DONE
   } xfer_e;

   typedef enum logic [2:0] {
      EVT_SELECT,
      EVT_DATA,
      EVT_RESET,
      EVT_DECLARED,
      EVT_INVALIDATED
   } evt_kind_e;

   typedef struct packed {
      evt_kind_e   kind;
      logic [1:0]  dom;
      logic [7:0]  data;
      logic        selected;
      logic        addr_valid;
      logic [5:0]  op_addr;
   } link_evt_s;

endpackage

//--- toggle_word_cdc.sv
// Word crossing by a toggle event with the word held stable in the source domain.
`timescale 1ns/1ps
module toggle_word_cdc #(
   parameter int WIDTH = 8
) (
   // Source side
   input  wire logic             src_clk_i,
   input  wire logic             src_rstn_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] data_i,
   // Destination side
   input  wire logic             dst_clk_i,
   input  wire logic             dst_rstn_i,
   output logic                  valid_o,
   output logic      [WIDTH-1:0] data_o
);

   logic [WIDTH-1:0] hold;
   logic             tog;
   logic             sync1;
   logic             sync2;
   logic             sync3;
   wire              seen = sync2 ^ sync3;

   // A second load before the first has been seen would tear the word, so loads must be spaced.
   always_ff @(posedge src_clk_i or negedge src_rstn_i)
   begin
      if (!src_rstn_i)
      begin
         hold <= '0;
         tog  <= 1'b0;
      end
      else if (load_i)
      begin
         hold <= data_i;
         tog  <= ~tog;
      end
   end

   always_ff @(posedge dst_clk_i or negedge dst_rstn_i)
   begin
      if (!dst_rstn_i)
      begin
         sync1   <= 1'b0;
         sync2   <= 1'b0;
         sync3   <= 1'b0;
         valid_o <= 1'b0;
         data_o  <= '0;
      end
      else
      begin
         sync1   <= tog;
         sync2   <= sync1;
         sync3   <= sync2;
         valid_o <= seen;
         if (seen)
         begin
            data_o <= hold;
         end
      end
   end

endmodule

//--- id_code_rom.sv
// Table of selectable identification codes with a registered byte output.
`timescale 1ns/1ps
`include "three_wire_regs.svh"
module id_code_rom #(
   parameter int SEL_W = 2,
   parameter int IDX_W = 2
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // Lookup
   input  wire logic [SEL_W-1:0] sel_i,
   input  wire logic [IDX_W-1:0] idx_i,
   output logic            [7:0] byte_o
);

   function automatic logic [23:0] code_of(input logic [SEL_W-1:0] sel);
      case (sel)
         2'h0:    code_of = `ID_CODE_0;
         2'h1:    code_of = `ID_CODE_1;
         2'h2:    code_of = `ID_CODE_2;
         default: code_of = `ID_CODE_3;
      endcase
   endfunction

   wire [23:0] code = code_of(sel_i);
   wire  [7:0] pick = (idx_i == `IDX_FIRST)  ? code[7:0]  :
                      (idx_i == `IDX_SECOND) ? code[15:8] : code[23:16];

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         byte_o <= 8'h00;
      end
      else
      begin
         byte_o <= pick;
      end
   end

endmodule

//--- three_wire_ctrl_ext_addressing.sv
// Three-wire control bus slave with address decode, byte framing and extended addressing.
`timescale 1ns/1ps
`include "three_wire_regs.svh"

// Functional notes
// - Special address with mode bits hi 0, lo 1 starts an address declaration.
// - Declaration carries code bytes then an address byte; its six bits adopted.
// - Code byte bit 0 set means another code byte follows; clear means last.
// - Special address with mode bits hi 1, lo 0 starts an address invalidation.
// - Invalidation sends only the code; matching device drops address, stays silent.
// - Special address with both mode bits one is treated as interface reset.
// - Code and address bytes travel bit 0 first, bit 7 last.
// - All devices decode each address byte; only the matching one joins data.
// - Mode line low between bytes must work; held high also accepted here.
// - Selection persists after a transfer until another address byte arrives.
// - Special address ends any transfer; device stops taking part.
// - Strap pins select the one identification code this device answers to.
// - Address byte has mode bits in positions 0 and 1, address in 2 to 7.
// - Address phase is mode low, eight clock pulses, mode raised at the end.
// - Data phase keeps mode high, least significant bit first, stable while clock low.
// - Special address with both mode bits zero is the interface reset.
module three_wire_ctrl_ext_addressing #(
   parameter int STRAP_W = 2
) (
   // System clock and reset
   input  wire logic               clk_i,
   input  wire logic               rstn_i,
   // Control bus, clocked by the host's bit clock
   input  wire logic               ctrl_bit_clock_i,
   input  wire logic               ctrl_mode_line_i,
   input  wire logic               ctrl_data_line_i,
   output logic                    ctrl_data_line_o,
   output logic                    ctrl_data_line_oe_o,
   // Identification code select strap
   input  wire logic [STRAP_W-1:0] strap_i,
   // Received events, system side
   output logic                    rx_valid_o,
   output three_wire_pkg::evt_kind_e rx_kind_o,
   output logic              [1:0] rx_dom_o,
   output logic              [7:0] rx_data_o,
   // Status, system side
   output logic                    selected_o,
   output logic                    addr_valid_o,
   output logic              [5:0] op_addr_o,
   // Byte to be read by the host, system side
   input  wire logic               tx_load_i,
   input  wire logic         [7:0] tx_data_i
);

   // ****************************************************************
   // Link domain state
   // ****************************************************************
   // The link logic runs on the host's bit clock, which stands still between frames.
   // Its reset is the raw asynchronous reset: a synchroniser would swallow the first
   // edges of the first address byte, and the host keeps the clock idle around reset.
   logic                     prev_mode;
   logic               [2:0] bit_cnt;
   logic               [7:0] shift;
   three_wire_pkg::xfer_e    xfer;
   logic               [1:0] idx;
   logic               [5:0] own_addr;
   logic                     addr_valid;
   logic                     selected;
   logic               [1:0] dom;
   logic               [7:0] tx_shift;
   logic         [STRAP_W-1:0] strap_s1;
   logic         [STRAP_W-1:0] strap_s2;

   logic               [7:0] rom_byte;
   logic               [7:0] tx_byte;

   three_wire_pkg::xfer_e    next_xfer;
   logic               [1:0] next_idx;
   logic               [5:0] next_own_addr;
   logic                     next_addr_valid;
   logic                     next_selected;
   logic               [1:0] next_dom;
   logic                     evt_fire;
   three_wire_pkg::evt_kind_e evt_kind;

   three_wire_pkg::link_evt_s evt_word;
   three_wire_pkg::link_evt_s rx_word;
   logic                     rx_seen;

   // ****************************************************************
   // Bit framing
   // ****************************************************************
   // A change of mode level between two clock edges restarts the bit count; the count wraps after eight bits, so both
   // the halt pause and a mode line held high between data bytes frame correctly.
   wire       phase_change = ctrl_mode_line_i != prev_mode;
   wire [2:0] bit_pos      = phase_change ? `BIT_FIRST : bit_cnt;
   wire [7:0] next_shift   = {ctrl_data_line_i, shift[7:1]};
   wire       byte_done    = bit_pos == `BIT_LAST;
   wire       addr_done    = byte_done & ~ctrl_mode_line_i;
   wire       data_done    = byte_done & ctrl_mode_line_i;

   // ****************************************************************
   // Byte decode
   // ****************************************************************
   wire [5:0] rx_oa      = next_shift[`OA_MSB:`OA_LSB];
   wire [1:0] rx_dom     = next_shift[`DOM_HI_BIT:`DOM_LO_BIT];
   wire       is_special = rx_oa == `SPECIAL_OA;
   wire       oa_match   = addr_valid & (rx_oa == own_addr);
   wire       id_match   = next_shift == rom_byte;
   wire       id_last    = ~next_shift[`ID_CONT_BIT];
   wire       read_dir   = dom[`DOM_LO_BIT];
   wire       read_act   = selected & read_dir & (xfer == three_wire_pkg::XFER_ACTIVE);

   // ****************************************************************
   // Transfer sequencing
   // ****************************************************************
   always_comb
   begin
      next_xfer       = xfer;
      next_idx        = idx;
      next_own_addr   = own_addr;
      next_addr_valid = addr_valid;
      next_selected   = selected;
      next_dom        = dom;
      evt_fire        = 1'b0;
      evt_kind        = three_wire_pkg::EVT_DATA;
      if (addr_done)
      begin
         next_idx = `IDX_FIRST;
         evt_fire = 1'b1;
         if (is_special)
         begin
            // Any special address ends the running transfer.
            next_selected = 1'b0;
            next_dom      = rx_dom;
            case (rx_dom)
               `DOM_DECLARE:
               begin
                  next_xfer = three_wire_pkg::XFER_DECL_ID;
                  evt_kind  = three_wire_pkg::EVT_RESET;
               end
               `DOM_INVALIDATE:
               begin
                  next_xfer = three_wire_pkg::XFER_INVAL_ID;
                  evt_kind  = three_wire_pkg::EVT_RESET;
               end
               `DOM_RESERVED:
               begin
                  next_xfer = three_wire_pkg::XFER_IDLE;
                  evt_kind  = three_wire_pkg::EVT_RESET;
               end
               default:
               begin
                  next_xfer = three_wire_pkg::XFER_IDLE;
                  evt_kind  = three_wire_pkg::EVT_RESET;
               end
            endcase
         end
         else if (oa_match)
         begin
            next_selected = 1'b1;
            next_dom      = rx_dom;
            next_xfer     = three_wire_pkg::XFER_ACTIVE;
            evt_kind      = three_wire_pkg::EVT_SELECT;
         end
         else
         begin
            // Another device's address: stay out of the following data phase.
            next_selected = 1'b0;
            next_xfer     = three_wire_pkg::XFER_IDLE;
            evt_fire      = 1'b0;
         end
      end
      else if (data_done)
      begin
         case (xfer)
            three_wire_pkg::XFER_DECL_ID,
            three_wire_pkg::XFER_INVAL_ID:
            begin
               if (!id_match)
               begin
                  next_xfer = three_wire_pkg::XFER_DONE;
               end
               else if (!id_last)
               begin
                  next_idx = idx + 2'h1;
               end
               else if (xfer == three_wire_pkg::XFER_DECL_ID)
               begin
                  next_xfer = three_wire_pkg::XFER_DECL_ADDR;
               end
               else
               begin
                  next_addr_valid = 1'b0;
                  next_selected   = 1'b0;
                  next_xfer       = three_wire_pkg::XFER_DONE;
                  evt_fire        = 1'b1;
                  evt_kind        = three_wire_pkg::EVT_INVALIDATED;
               end
            end
            three_wire_pkg::XFER_DECL_ADDR:
            begin
               // Mode bits of this byte carry no meaning and are dropped.
               next_own_addr   = rx_oa;
               next_addr_valid = ~is_special;
               next_xfer       = three_wire_pkg::XFER_DONE;
               evt_fire        = 1'b1;
               evt_kind        = three_wire_pkg::EVT_DECLARED;
            end
            three_wire_pkg::XFER_ACTIVE:
            begin
               // Selection stays in force after the byte, so further bytes need no address.
               evt_fire = ~read_dir;
               evt_kind = three_wire_pkg::EVT_DATA;
            end
            three_wire_pkg::XFER_IDLE,
            three_wire_pkg::XFER_DONE:
            begin
               next_xfer = xfer;
            end
            default:
            begin
               next_xfer = three_wire_pkg::XFER_IDLE;
            end
         endcase
      end
   end

   assign evt_word.kind       = evt_kind;
   assign evt_word.dom        = next_dom;
   assign evt_word.data       = next_shift;
   assign evt_word.selected   = next_selected;
   assign evt_word.addr_valid = next_addr_valid;
   assign evt_word.op_addr    = next_own_addr;

   // ****************************************************************
   // Link registers
   // ****************************************************************
   always_ff @(posedge ctrl_bit_clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prev_mode <= 1'b1;
         bit_cnt   <= `BIT_FIRST;
         shift     <= 8'h00;
      end
      else
      begin
         prev_mode <= ctrl_mode_line_i;
         bit_cnt   <= bit_pos + 3'h1;
         shift     <= next_shift;
      end
   end

   always_ff @(posedge ctrl_bit_clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         xfer       <= three_wire_pkg::XFER_IDLE;
         idx        <= `IDX_FIRST;
         own_addr   <= `SPECIAL_OA;
         addr_valid <= 1'b0;
         selected   <= 1'b0;
         dom        <= `DOM_RESET;
      end
      else
      begin
         xfer       <= next_xfer;
         idx        <= next_idx;
         own_addr   <= next_own_addr;
         addr_valid <= next_addr_valid;
         selected   <= next_selected;
         dom        <= next_dom;
      end
   end

   // The strap is static; the two stages only keep a pin from feeding logic directly.
   always_ff @(posedge ctrl_bit_clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         strap_s1 <= '0;
         strap_s2 <= '0;
      end
      else
      begin
         strap_s1 <= strap_i;
         strap_s2 <= strap_s1;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Bit 0 is loaded at the end of the address byte so it stands before the first
   // data clock; each rising edge then moves on to the next bit.
   wire load_tx  = (addr_done & oa_match & rx_dom[`DOM_LO_BIT]) | (data_done & read_act);
   wire shift_tx = read_act & ctrl_mode_line_i & ~byte_done;

   always_ff @(posedge ctrl_bit_clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_shift <= 8'h00;
      end
      else if (load_tx)
      begin
         tx_shift <= tx_byte;
      end
      else if (shift_tx)
      begin
         tx_shift <= {1'b0, tx_shift[7:1]};
      end
   end

   assign ctrl_data_line_o    = tx_shift[0];
   // Enable follows the mode line without a clock so the line is released in halt mode.
   assign ctrl_data_line_oe_o = read_act & ctrl_mode_line_i;

   // ****************************************************************
   // Code table and crossings
   // ****************************************************************
   id_code_rom #(
      .SEL_W (STRAP_W),
      .IDX_W (2)
   ) u_rom (
      .clk_i  (ctrl_bit_clock_i),
      .rstn_i (rstn_i),
      .sel_i  (strap_s2),
      .idx_i  (idx),
      .byte_o (rom_byte)
   );

   toggle_word_cdc #(
      .WIDTH ($bits(three_wire_pkg::link_evt_s))
   ) u_evt_cdc (
      .src_clk_i  (ctrl_bit_clock_i),
      .src_rstn_i (rstn_i),
      .load_i     (evt_fire),
      .data_i     (evt_word),
      .dst_clk_i  (clk_i),
      .dst_rstn_i (rstn_i),
      .valid_o    (rx_seen),
      .data_o     (rx_word)
   );

   toggle_word_cdc #(
      .WIDTH (8)
   ) u_tx_cdc (
      .src_clk_i  (clk_i),
      .src_rstn_i (rstn_i),
      .load_i     (tx_load_i),
      .data_i     (tx_data_i),
      .dst_clk_i  (ctrl_bit_clock_i),
      .dst_rstn_i (rstn_i),
      .valid_o    (),
      .data_o     (tx_byte)
   );

   // ****************************************************************
   // System side outputs
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_valid_o   <= 1'b0;
         rx_kind_o    <= three_wire_pkg::EVT_RESET;
         rx_dom_o     <= `DOM_RESET;
         rx_data_o    <= 8'h00;
         selected_o   <= 1'b0;
         addr_valid_o <= 1'b0;
         op_addr_o    <= `SPECIAL_OA;
      end
      else
      begin
         rx_valid_o <= rx_seen;
         if (rx_seen)
         begin
            rx_kind_o    <= rx_word.kind;
            rx_dom_o     <= rx_word.dom;
            rx_data_o    <= rx_word.data;
            selected_o   <= rx_word.selected;
            addr_valid_o <= rx_word.addr_valid;
            op_addr_o    <= rx_word.op_addr;
         end
      end
   end

endmodule

//--- three_wire_sva.sv
// Port assertions for the three-wire control slave.
`timescale 1ns/1ps
module three_wire_sva (
   // Clock, reset and bus
   input wire logic                      clk_i,
   input wire logic                      rstn_i,
   input wire logic                      ctrl_mode_line_i,
   input wire logic                      ctrl_data_line_oe_o,
   // Events and status
   input wire logic                      rx_valid_o,
   input wire three_wire_pkg::evt_kind_e rx_kind_o,
   input wire logic [1:0]                rx_dom_o,
   input wire logic [7:0]                rx_data_o,
   input wire logic                      selected_o,
   input wire logic                      addr_valid_o,
   input wire logic [5:0]                op_addr_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   wire logic ev_sel = rx_valid_o && rx_kind_o == three_wire_pkg::EVT_SELECT;
   wire logic ev_dat = rx_valid_o && rx_kind_o == three_wire_pkg::EVT_DATA;
   wire logic ev_rst = rx_valid_o && rx_kind_o == three_wire_pkg::EVT_RESET;
   wire logic ev_dec = rx_valid_o && rx_kind_o == three_wire_pkg::EVT_DECLARED;
   wire logic ev_inv = rx_valid_o && rx_kind_o == three_wire_pkg::EVT_INVALIDATED;
   a_valid_pulse: assert property (rx_valid_o |=> (!rx_valid_o) [*4])
      else $error("event strobe too long");
   a_oe_mode_high: assert property (ctrl_data_line_oe_o |-> ctrl_mode_line_i)
      else $error("data line driven with mode low");
   a_decl_adopt: assert property (ev_dec |-> op_addr_o == rx_data_o[7:2] && rx_dom_o == 2'h1 &&
      addr_valid_o == (rx_data_o[7:2] != 6'h00)) else $error("declared address not adopted");
   a_av_rise: assert property ($rose(addr_valid_o) |-> ev_dec)
      else $error("address valid without declaration");
   a_av_fall: assert property ($fell(addr_valid_o) |-> ev_inv)
      else $error("address lost without invalidation");
   a_inval_drop: assert property (ev_inv |-> !addr_valid_o && !selected_o && rx_dom_o == 2'h2)
      else $error("invalidation kept address");
   a_reset_desel: assert property (ev_rst |-> !selected_o && rx_data_o[7:2] == 6'h00)
      else $error("special address left device selected");
   a_sel_match: assert property (ev_sel |-> selected_o && addr_valid_o &&
      rx_data_o[7:2] == op_addr_o && rx_dom_o == rx_data_o[1:0]) else $error("selection without match");
   a_sel_cause: assert property ($rose(selected_o) |-> ev_sel)
      else $error("selected without address byte");
   a_data_sel: assert property (ev_dat |-> selected_o && addr_valid_o)
      else $error("data taken while not selected");
endmodule
bind three_wire_ctrl_ext_addressing three_wire_sva sva (.clk_i, .rstn_i, .ctrl_mode_line_i, .ctrl_data_line_oe_o,
   .rx_valid_o, .rx_kind_o, .rx_dom_o, .rx_data_o, .selected_o, .addr_valid_o, .op_addr_o);

//--- host_model.sv
// Host model driving the mode line and bit clock and sharing the data line.
`timescale 1ns/1ps
module host_model (
   // Bus lines
   output logic      ctrl_bit_clock_o,
   output logic      ctrl_mode_line_o,
   output logic      ctrl_data_line_o,
   output logic      ctrl_data_line_oe_o,
   input  wire logic ctrl_data_line_i
);
   initial
   begin
      ctrl_bit_clock_o = 1'b1;
      ctrl_mode_line_o = 1'b1;
      ctrl_data_line_o = 1'b0;
      ctrl_data_line_oe_o = 1'b0;
   end
   // The clock stands high outside a byte, so halts are told apart from addressing.
   task automatic xfer(input logic m, input logic [7:0] b, input logic rd, input logic halt, output logic [7:0] q);
      // All devices share the one mode line driven here, so identical parts are told apart by their identification codes.
      ctrl_mode_line_o = m;
      #60;
      for (int i = 0; i < 8; i++)
      begin
         ctrl_bit_clock_o = 1'b0;
         ctrl_data_line_o = b[i];
         ctrl_data_line_oe_o = !rd;
         #15;
         q[i] = ctrl_data_line_i;
         ctrl_bit_clock_o = 1'b1;
         #15;
      end
      #45;
      ctrl_data_line_oe_o = 1'b0;
      ctrl_mode_line_o = !(m && halt);
      #60;
   endtask
endmodule

//--- testbench.sv
// Self-checking bench for the three-wire control slave.
`timescale 1ns/1ps
module testbench;
   logic       clk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic [1:0] strap = 2'h0;
   logic       tx_load = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic       junk = 1'b0;
   logic       exp_sel = 1'b0;
   logic       exp_av = 1'b0;
   logic [5:0] exp_oa = 6'h00;
   logic [7:0] rxq, r, b;
   logic [5:0] a;
   int         err_count = 0;
   int         tests_run = 0;
   int         seed = 32'h155f318b;
   wire logic  bclk, mode, h_d, h_oe, d_o, d_oe, line, rx_valid, sel, av;
   wire logic [1:0] dom;
   wire logic [7:0] data;
   wire logic [5:0] oa;
   three_wire_pkg::evt_kind_e kind;
   three_wire_pkg::link_evt_s ev_q[$];
   always #10 clk_i = ~clk_i;
   // A released line shows a changing pattern, never its last level.
   always @(posedge clk_i) junk <= ~junk;
   assign line = d_oe ? d_o : (h_oe ? h_d : junk);
   always @(posedge clk_i) if (rx_valid === 1'b1) ev_q.push_back({kind, dom, data, sel, av, oa});
   three_wire_ctrl_ext_addressing dut (.clk_i(clk_i), .rstn_i(rstn_i), .ctrl_bit_clock_i(bclk),
      .ctrl_mode_line_i(mode), .ctrl_data_line_i(line), .ctrl_data_line_o(d_o), .ctrl_data_line_oe_o(d_oe),
      .strap_i(strap), .rx_valid_o(rx_valid), .rx_kind_o(kind), .rx_dom_o(dom), .rx_data_o(data),
      .selected_o(sel), .addr_valid_o(av), .op_addr_o(oa), .tx_load_i(tx_load), .tx_data_i(tx_data));
   host_model host (.ctrl_bit_clock_o(bclk), .ctrl_mode_line_o(mode), .ctrl_data_line_o(h_d),
      .ctrl_data_line_oe_o(h_oe), .ctrl_data_line_i(line));
   function automatic logic [7:0] code3(input logic [1:0] s);
      return 8'h4a + {5'h00, s, 1'b0};
   endfunction
   task automatic check(input string n, input logic [20:0] seen, input logic [20:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic send(input logic m, input logic [7:0] v);
      host.xfer(m, v, 1'b0, 1'b1, rxq);
   endtask
   task automatic send_code(input logic [7:0] last);
      send(1'b1, 8'hc3);
      send(1'b1, 8'h35);
      send(1'b1, last);
   endtask
   task automatic expect_evt(input three_wire_pkg::evt_kind_e k, input logic [1:0] m, input logic [7:0] d);
      three_wire_pkg::link_evt_s e;
      for (int i = 0; i < 40 && ev_q.size() == 0; i++) @(posedge clk_i);
      if (ev_q.size() == 0)
      begin
         err_count++;
         $display("[ERR] event expected %h seen none", d);
         close_out();
      end
      else
      begin
         e = ev_q.pop_front();
         check("event", e, {k, m, d, exp_sel, exp_av, exp_oa});
      end
   endtask
   task automatic expect_none();
      repeat (8) @(posedge clk_i);
      check("no event", 21'(ev_q.size()), 21'h0);
      ev_q.delete();
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      strap <= 2'($random(seed));
      a = {3'h7, 3'($random(seed))};
      b = {a, 2'($random(seed))};
      repeat (4) @(posedge clk_i);
      check("reset state", 21'({av, d_oe, sel}), 21'h0);
      send(1'b0, {a, 2'h0});
      expect_none();
      send(1'b0, 8'h01);
      expect_evt(three_wire_pkg::EVT_RESET, 2'h1, 8'h01);
      send_code(code3(strap + 2'h1));
      send(1'b1, b);
      expect_none();
      $display("test wrong code done");
      send(1'b0, 8'h01);
      expect_evt(three_wire_pkg::EVT_RESET, 2'h1, 8'h01);
      send_code(code3(strap));
      send(1'b1, b);
      exp_av = 1'b1;
      exp_oa = a;
      expect_evt(three_wire_pkg::EVT_DECLARED, 2'h1, b);
      send(1'b0, {a, 2'h0});
      exp_sel = 1'b1;
      expect_evt(three_wire_pkg::EVT_SELECT, 2'h0, {a, 2'h0});
      for (int k = 0; k < 4; k++)
      begin
         r = 8'($random(seed));
         host.xfer(1'b1, r, 1'b0, k[0], rxq);
         expect_evt(three_wire_pkg::EVT_DATA, 2'h0, r);
      end
      $display("test declare and write done");
      r = 8'($random(seed));
      @(posedge clk_i);
      tx_data <= r;
      tx_load <= 1'b1;
      @(posedge clk_i);
      tx_load <= 1'b0;
      send(1'b0, {a, 2'h1});
      expect_evt(three_wire_pkg::EVT_SELECT, 2'h1, {a, 2'h1});
      for (int k = 0; k < 2; k++)
      begin
         host.xfer(1'b1, 8'h00, 1'b1, k[0], rxq);
         check("read byte", 21'(rxq), 21'(r));
      end
      for (int k = 0; k < 2; k++)
      begin
         b = k ? 8'h00 : 8'h03;
         send(1'b0, b);
         exp_sel = 1'b0;
         expect_evt(three_wire_pkg::EVT_RESET, b[1:0], b);
         send(1'b1, 8'h5a);
         expect_none();
      end
      send(1'b0, {a, 2'h0});
      exp_sel = 1'b1;
      expect_evt(three_wire_pkg::EVT_SELECT, 2'h0, {a, 2'h0});
      $display("test read and special done");
      send(1'b0, 8'h02);
      exp_sel = 1'b0;
      expect_evt(three_wire_pkg::EVT_RESET, 2'h2, 8'h02);
      send_code(code3(strap));
      exp_av = 1'b0;
      expect_evt(three_wire_pkg::EVT_INVALIDATED, 2'h2, code3(strap));
      send(1'b0, {a, 2'h0});
      expect_none();
      $display("test invalidate done");
      close_out();
   end
endmodule
